// *** mcu_exec_pkg.sv ***
`default_nettype none

package mcu_exec_pkg;

   // Widths of the datapath.
   localparam int WORD_W = 12;
   localparam int PC_W = 11;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 5;
   localparam int JUMP_W = 9;
   localparam int PAGE_W = 2;
   localparam int STATUS_W = 8;

   // Reset values.
   localparam logic [PC_W-1:0] RESET_PC = 11'h000;
   localparam logic [DATA_W-1:0] RESET_ACC = 8'h00;
   localparam logic RESET_ZERO = 1'h0;

   // Field positions inside an instruction word.
   localparam int MAJOR_HI = 11;
   localparam int MAJOR_LO = 9;
   localparam int FUNC_HI = 8;
   localparam int FUNC_LO = 6;
   localparam int DEST_BIT = 5;
   localparam int FADDR_HI = 4;
   localparam int FADDR_LO = 0;
   localparam int JUMP_HI = 8;
   localparam int LIT_HI = 7;

   // Page bits: where they sit in the status register.
   localparam int STATUS_PAGE_HI = 6;
   localparam int STATUS_PAGE_LO = 5;

   // Major and function codes of the instruction word.
   localparam logic [2:0] MAJOR_FILE = 3'h0;
   localparam logic [2:0] MAJOR_JUMP = 3'h5;
   localparam logic [2:0] MAJOR_OR_LIT = 3'h6;
   localparam logic [2:0] FUNC_IDLE = 3'h0;
   localparam logic [2:0] FUNC_STORE = 3'h1;
   localparam logic [2:0] FUNC_OR = 3'h2;
   localparam logic [2:0] FUNC_MOVE = 3'h3;
   localparam logic [2:0] FUNC_INC_SKIP = 3'h4;

   // Destination select.
   localparam logic DEST_TO_ACC = 1'h0;
   localparam logic DEST_TO_FILE = 1'h1;

   typedef enum logic [2:0] {
      OP_IDLE = 3'b000,
      OP_STORE = 3'b001,
      OP_OR_FILE = 3'b010,
      OP_MOVE_FILE = 3'b011,
      OP_INC_SKIP = 3'b100,
      OP_JUMP = 3'b101,
      OP_OR_LIT = 3'b110
   } op_e;

   typedef enum logic [0:0] {
      SLOT_RUN = 1'b0,
      SLOT_DISCARD = 1'b1
   } slot_e;

   typedef struct packed {
      logic en;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } file_write_s;

   typedef struct packed {
      op_e op;
      logic target_select;
      logic [FADDR_W-1:0] faddr;
      logic [JUMP_W-1:0] k;
   } decoded_s;

endpackage

`default_nettype wire

// *** mcu_instruction_subset_exec.sv ***
`default_nettype none

// Contract
// - Increment-skip adds one to register, result to accumulator or register, flags untouched.
// - Zero increment result discards the prefetched next word, running an idle slot.
// - Unconditional jump loads its nine-bit immediate into program counter bits 8 to 0.
// - Unconditional jump fills program counter bits 10 and 9 from status bits 6 and 5.
// - Unconditional jump takes two cycles and leaves every flag unchanged.
// - OR literal ORs accumulator with eight-bit immediate into accumulator, updating zero.
// - OR with file ORs accumulator with register, result per target_select, updating zero.
// - Store copies accumulator into the addressed register, flags untouched.
// - Move file copies register to accumulator or back to the same register.
// - Move file updates zero from the moved value even when writing back.
module mcu_instruction_subset_exec
   import mcu_exec_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Fetch pipeline.
   input wire logic [WORD_W-1:0] instr_word,
   output logic [PC_W-1:0] fetch_addr,
   output logic slot_discard,
   // Status register of the core.
   input wire logic [STATUS_W-1:0] status_reg,
   output logic zero_flag,
   // File register read port.
   output logic [FADDR_W-1:0] file_raddr,
   input wire logic [DATA_W-1:0] file_rdata,
   // File register write port.
   output logic file_we,
   output logic [FADDR_W-1:0] file_waddr,
   output logic [DATA_W-1:0] file_wdata,
   // Accumulator.
   output logic [DATA_W-1:0] accumulator
);

   decoded_s dec;
   logic [2:0] major;
   logic [2:0] func;
   logic [DATA_W-1:0] operand;
   logic [DATA_W-1:0] literal;
   logic [DATA_W-1:0] result;
   logic [PAGE_W-1:0] page;
   logic result_valid;
   logic result_to_file;
   logic affects_zero;
   logic skip_next;
   logic take_jump;

   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   slot_e slot_q;
   slot_e slot_d;
   logic [DATA_W-1:0] acc_q;
   logic [DATA_W-1:0] acc_d;
   logic zero_q;
   logic zero_d;
   file_write_s wr_q;
   file_write_s wr_d;

   // Decode the word; a discarded slot and unknown codes run as the idle instruction.
   always_comb begin
      major = instr_word[MAJOR_HI:MAJOR_LO];
      func = instr_word[FUNC_HI:FUNC_LO];
      dec.op = OP_IDLE;
      dec.target_select = instr_word[DEST_BIT];
      dec.faddr = instr_word[FADDR_HI:FADDR_LO];
      dec.k = instr_word[JUMP_HI:0];
      if (slot_q == SLOT_DISCARD) begin
         dec.op = OP_IDLE;
      end else begin
         unique case (major)
            MAJOR_FILE: begin
               unique case (func)
                  FUNC_IDLE: dec.op = OP_IDLE;
                  FUNC_STORE: dec.op = OP_STORE;
                  FUNC_OR: dec.op = OP_OR_FILE;
                  FUNC_MOVE: dec.op = OP_MOVE_FILE;
                  FUNC_INC_SKIP: dec.op = OP_INC_SKIP;
                  default: dec.op = OP_IDLE;
               endcase
            end
            MAJOR_JUMP: dec.op = OP_JUMP;
            MAJOR_OR_LIT: dec.op = OP_OR_LIT;
            default: dec.op = OP_IDLE;
         endcase
      end
   end

   // Operand read; a write still pending to the same address is forwarded.
   always_comb begin
      file_raddr = dec.faddr;
      if (wr_q.en && (wr_q.addr == dec.faddr)) begin
         operand = wr_q.data;
      end else begin
         operand = file_rdata;
      end
      literal = dec.k[LIT_HI:0];
      page = status_reg[STATUS_PAGE_HI:STATUS_PAGE_LO];
   end

   // Arithmetic and logic of the supported instructions.
   always_comb begin
      result = '0;
      result_valid = 1'b0;
      result_to_file = 1'b0;
      affects_zero = 1'b0;
      skip_next = 1'b0;
      take_jump = 1'b0;
      unique case (dec.op)
         OP_IDLE: begin
            result_valid = 1'b0;
         end
         OP_INC_SKIP: begin
            result = operand + 8'h01;
            result_valid = 1'b1;
            result_to_file = (dec.target_select == DEST_TO_FILE);
            skip_next = (result == 8'h00);
         end
         OP_JUMP: begin
            take_jump = 1'b1;
         end
         OP_OR_LIT: begin
            result = acc_q | literal;
            result_valid = 1'b1;
            result_to_file = 1'b0;
            affects_zero = 1'b1;
         end
         OP_OR_FILE: begin
            result = acc_q | operand;
            result_valid = 1'b1;
            result_to_file = (dec.target_select == DEST_TO_FILE);
            affects_zero = 1'b1;
         end
         OP_STORE: begin
            result = acc_q;
            result_valid = 1'b1;
            result_to_file = 1'b1;
         end
         OP_MOVE_FILE: begin
            result = operand;
            result_valid = 1'b1;
            result_to_file = (dec.target_select == DEST_TO_FILE);
            affects_zero = 1'b1;
         end
         default: begin
            result_valid = 1'b0;
         end
      endcase
   end

   // Next state of program counter and slot.
   always_comb begin
      pc_d = pc_q + 11'h001;
      slot_d = SLOT_RUN;
      if (take_jump) begin
         pc_d = {page, dec.k};
         // The word already fetched behind the jump is thrown away.
         slot_d = SLOT_DISCARD;
      end else if (skip_next) begin
         slot_d = SLOT_DISCARD;
      end
   end

   // Next state of accumulator, zero flag and file write.
   always_comb begin
      acc_d = acc_q;
      zero_d = zero_q;
      wr_d.en = 1'b0;
      wr_d.addr = dec.faddr;
      wr_d.data = result;
      if (result_valid && !result_to_file) begin
         acc_d = result;
      end
      if (result_valid && result_to_file) begin
         wr_d.en = 1'b1;
      end
      if (affects_zero) begin
         zero_d = (result == 8'h00);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pc_q <= RESET_PC;
         slot_q <= SLOT_DISCARD;
         acc_q <= RESET_ACC;
         zero_q <= RESET_ZERO;
         wr_q <= '0;
      end else begin
         pc_q <= pc_d;
         slot_q <= slot_d;
         acc_q <= acc_d;
         zero_q <= zero_d;
         wr_q <= wr_d;
      end
   end

   assign fetch_addr = pc_q;
   assign slot_discard = (slot_q == SLOT_DISCARD);
   assign zero_flag = zero_q;
   assign accumulator = acc_q;
   assign file_we = wr_q.en;
   assign file_waddr = wr_q.addr;
   assign file_wdata = wr_q.data;

endmodule // mcu_instruction_subset_exec

`default_nettype wire

// *** exec_props.sv ***
`default_nettype none
module exec_props
   import mcu_exec_pkg::*;
(
   // Core side.
   input wire logic clock,
   input wire logic rst,
   input wire logic [WORD_W-1:0] instr_word,
   input wire logic [PC_W-1:0] fetch_addr,
   input wire logic slot_discard,
   input wire logic [STATUS_W-1:0] status_reg,
   input wire logic zero_flag,
   input wire logic [DATA_W-1:0] accumulator,
   // File port.
   input wire logic [FADDR_W-1:0] file_raddr,
   input wire logic [DATA_W-1:0] file_rdata,
   input wire logic file_we,
   input wire logic [FADDR_W-1:0] file_waddr,
   input wire logic [DATA_W-1:0] file_wdata
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [DATA_W-1:0] src;
   logic [2:0] fn;
   logic [1:0] pg;
   logic fg, t, j;
   // A write still pending from the last cycle to the same address overrides the memory's data.
   assign src = (file_we && file_waddr == file_raddr) ? file_wdata : file_rdata;
   assign fg = !slot_discard && instr_word[11:9] == MAJOR_FILE;
   assign j = !slot_discard && instr_word[11:9] == MAJOR_JUMP;
   assign fn = instr_word[8:6];
   assign t = instr_word[5];
   assign pg = status_reg[6:5];
   property p_inc;
      fg && fn == FUNC_INC_SKIP && !t |=> accumulator == $past(src) + 8'h01 && $stable(zero_flag);
   endproperty
   a_inc: assert property (p_inc) else $error("inc result wrong");
   property p_skip;
      fg && fn == FUNC_INC_SKIP |=> slot_discard == ($past(src) == 8'hFF);
   endproperty
   a_skip: assert property (p_skip) else $error("skip wrong");
   property p_jump;
      j |=> slot_discard && fetch_addr == {$past(pg), $past(instr_word[8:0])};
   endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong");
   property p_jump_len;
      j |=> $stable(zero_flag) ##1 !slot_discard;
   endproperty
   a_jump_len: assert property (p_jump_len) else $error("jump length wrong");
   property p_or_lit;
      !slot_discard && instr_word[11:9] == MAJOR_OR_LIT |=>
         accumulator == ($past(accumulator) | $past(instr_word[7:0])) && zero_flag == (accumulator == 8'h00);
   endproperty
   a_or_lit: assert property (p_or_lit) else $error("or literal wrong");
   property p_or_file;
      fg && fn == FUNC_OR && t |=> file_we && file_wdata == ($past(accumulator) | $past(src))
         && zero_flag == (file_wdata == 8'h00);
   endproperty
   a_or_file: assert property (p_or_file) else $error("or file wrong");
   property p_store;
      fg && fn == FUNC_STORE |=> file_we && file_waddr == $past(file_raddr) && file_wdata == $past(accumulator)
         && $stable(zero_flag);
   endproperty
   a_store: assert property (p_store) else $error("store wrong");
   property p_move;
      fg && fn == FUNC_MOVE && !t |=> accumulator == $past(src) && zero_flag == (accumulator == 8'h00);
   endproperty
   a_move: assert property (p_move) else $error("move wrong");
   property p_move_back;
      fg && fn == FUNC_MOVE && t |=> file_we && file_wdata == $past(src) && zero_flag == (file_wdata == 8'h00);
   endproperty
   a_move_back: assert property (p_move_back) else $error("move back wrong");
endmodule // exec_props
bind mcu_instruction_subset_exec exec_props u_props (.clock(clock), .rst(rst), .instr_word(instr_word),
   .fetch_addr(fetch_addr), .slot_discard(slot_discard), .status_reg(status_reg), .zero_flag(zero_flag),
   .accumulator(accumulator), .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
   .file_waddr(file_waddr), .file_wdata(file_wdata));
`default_nettype wire

// *** mcu_instruction_subset_exec_test.sv ***
`default_nettype none
module mcu_instruction_subset_exec_test
   import mcu_exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [WORD_W-1:0] instr_word = 12'h000;
   logic [STATUS_W-1:0] status_reg = 8'h00;
   logic [DATA_W-1:0] file_rdata = 8'h00;
   logic [DATA_W-1:0] file_wdata, accumulator;
   logic [PC_W-1:0] fetch_addr;
   logic [FADDR_W-1:0] file_raddr, file_waddr;
   logic slot_discard, zero_flag, file_we;
   int n_errors = 0;
   int total_checks = 0;
   always #25 clock = ~clock;
   mcu_instruction_subset_exec u_dut (.clock(clock), .rst(rst), .instr_word(instr_word),
      .fetch_addr(fetch_addr), .slot_discard(slot_discard), .status_reg(status_reg), .zero_flag(zero_flag),
      .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
      .file_wdata(file_wdata), .accumulator(accumulator));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Presents one word for one execute edge, then idles; outputs are settled on return.
   task automatic run(input logic [11:0] w, input logic [7:0] d);
      @(posedge clock);
      instr_word <= w;
      file_rdata <= d;
      @(posedge clock);
      instr_word <= 12'h000;
      #1;
   endtask
   task automatic t_or;
      run(12'hC00, 8'h00);
      chk(zero_flag, 1'b1);
      run(12'hC5A, 8'h00);
      chk({zero_flag, accumulator}, 9'h05A);
      run(12'h0A2, 8'hA5);
      chk({file_we, file_waddr, file_wdata, zero_flag}, 15'h45FE);
      $display("or tests done");
   endtask
   task automatic t_move_store;
      run(12'h0E4, 8'h00);
      chk({file_we, file_waddr, file_wdata, zero_flag}, 15'h4801);
      run(12'h069, 8'h00);
      chk({file_we, file_waddr, file_wdata, zero_flag}, 15'h52B5);
      $display("move and store tests done");
   endtask
   task automatic t_skip;
      run(12'h103, 8'h41);
      chk({accumulator, zero_flag, slot_discard}, 10'h10A);
      // The word behind a zero result is an OR literal that must be thrown away.
      @(posedge clock);
      instr_word <= 12'h127;
      file_rdata <= 8'hFF;
      #1;
      chk(file_raddr, 5'h07);
      @(posedge clock);
      instr_word <= 12'hCFF;
      #1;
      chk({file_we, file_waddr, file_wdata, zero_flag, slot_discard}, 16'h9C03);
      @(posedge clock);
      instr_word <= 12'h000;
      #1;
      chk({accumulator, slot_discard}, 9'h084);
      run(12'h0C4, 8'h80);
      chk({accumulator, zero_flag}, 9'h100);
      $display("increment tests done");
   endtask
   task automatic t_jump(input logic [7:0] st, input logic [8:0] k, input logic [10:0] exp);
      @(posedge clock);
      status_reg <= st;
      run({3'h5, k}, 8'h00);
      chk({fetch_addr, slot_discard, zero_flag}, {exp, 2'b10});
      @(posedge clock);
      #1;
      chk({fetch_addr, slot_discard}, {exp + 11'h001, 1'b0});
      $display("jump test done");
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      t_or();
      t_move_store();
      t_skip();
      t_jump(8'h60, 9'h1FF, 11'h7FF);
      t_jump(8'h20, 9'h000, 11'h200);
      report_and_stop();
   end
endmodule // mcu_instruction_subset_exec_test
`default_nettype wire
